// *** hdl/ssw_pkg.sv ***
// package for the supply supervisor reset generator: timing constants and types
// assumes a single 10 MHz clock; analog comparators live outside this block
package ssw_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned HOLD_DELAY_MS = 180;
    // least time, so round up to whole cycles
    localparam longint unsigned HOLD_CYCLES_L =
        (longint'(HOLD_DELAY_MS) * CLK_HZ + 999) / 1000;
    localparam int unsigned HOLD_CYCLES = int'(HOLD_CYCLES_L);
    // watchdog timeout default, counted in clock cycles
    localparam int unsigned WDOG_TIMEOUT_CYCLES = 16_000_000;
    localparam int unsigned CNT_W = 32;

    // reset values
    localparam logic RST_ASSERTED_N = 1'b0;

    // synchronised pin levels
    typedef struct packed {
        logic below;
        logic above;
        logic mr_n;
        logic kick;
    } ssw_pins_t;

    // outputs to the system
    typedef struct packed {
        logic reset_n;
        logic reset_hi;
    } ssw_rst_out_t;

    typedef enum logic [1:0] {
        SSW_HOLD,
        SSW_RUN
    } ssw_phase_t;

endpackage : ssw_pkg

// *** hdl/ssw_supervisor.sv ***
// supply supervisor reset generator with manual reset and watchdog
// assumes comparator outputs, manual reset and kick arrive asynchronously
`timescale 1ns/1ps

module ssw_supervisor #(
    parameter int unsigned WDOG_CYCLES = ssw_pkg::WDOG_TIMEOUT_CYCLES,
    parameter int unsigned HOLD_CYC = ssw_pkg::HOLD_CYCLES,
    parameter bit HAS_MR = 1'b1,
    parameter bit HAS_WDOG = 1'b1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic below_lower_trip,
    input wire logic above_upper_trip,
    input wire logic manual_reset_n,
    input wire logic watchdog_kick_input,
    output ssw_pkg::ssw_rst_out_t rst_out
);
    import ssw_pkg::*;

    // ==========================================================
    // elaboration checks
    // a watchdog below two cycles would fire on the edge that clears it
    if (WDOG_CYCLES < 2) begin : g_bad_wdog
        $error("ssw_supervisor: watchdog count too small");
    end
    // a zero hold would wrap the end count to all ones and hold reset for about 2^32 cycles
    if (HOLD_CYC < 1) begin : g_bad_hold
        $error("ssw_supervisor: hold count too small");
    end

    typedef struct packed {
        ssw_pins_t s1;
        ssw_pins_t s2;
        logic kick_d;
        logic supply_low;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] wdog_cnt;
        logic wdog_fire;
        ssw_phase_t phase;
        ssw_rst_out_t out;
    } ssw_state_t;

    ssw_state_t st;
    ssw_state_t next_st;
    ssw_pins_t raw;
    logic mr_active;
    logic kick_edge;
    logic any_cause;

    // ==========================================================
    // combinational next state
    always_comb begin
        next_st = st;
        raw.below = below_lower_trip;
        raw.above = above_upper_trip;
        // without manual reset the pin reads as released
        raw.mr_n = HAS_MR ? manual_reset_n : 1'b1;
        raw.kick = watchdog_kick_input;
        // two-flop synchronisers; stage one feeds stage two only
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.kick_d = st.s2.kick;
        // hysteresis: enter at lower, leave only above upper
        if (st.s2.below) begin
            next_st.supply_low = 1'b1;
        end else if (st.s2.above) begin
            next_st.supply_low = 1'b0;
        end
        mr_active = !st.s2.mr_n;
        kick_edge = st.s2.kick ^ st.kick_d;
        // watchdog fire only counts with supply good
        any_cause = st.supply_low || mr_active || (st.wdog_fire && !st.supply_low);
        // watchdog: cleared on edge or while reset is out
        next_st.wdog_fire = 1'b0;
        if (!HAS_WDOG || kick_edge || st.phase == SSW_HOLD || any_cause) begin
            next_st.wdog_cnt = '0;
        end else if (st.wdog_cnt >= CNT_W'(WDOG_CYCLES - 1)) begin
            next_st.wdog_cnt = '0;
            next_st.wdog_fire = 1'b1;
        end else begin
            next_st.wdog_cnt = st.wdog_cnt + CNT_W'(1);
        end
        // single hold counter restarts while any cause holds
        case (st.phase)
            SSW_HOLD: begin
                if (any_cause) begin
                    next_st.hold_cnt = '0;
                end else if (st.hold_cnt >= CNT_W'(HOLD_CYC - 1)) begin
                    next_st.phase = SSW_RUN;
                end else begin
                    next_st.hold_cnt = st.hold_cnt + CNT_W'(1);
                end
            end
            SSW_RUN: begin
                if (any_cause) begin
                    next_st.phase = SSW_HOLD;
                    next_st.hold_cnt = '0;
                end
            end
            default: begin
                next_st.phase = SSW_HOLD;
            end
        endcase
        // both polarities from the same state
        next_st.out.reset_n = (next_st.phase == SSW_RUN);
        next_st.out.reset_hi = (next_st.phase != SSW_RUN);
    end

    // ==========================================================
    // state register; reset starts in hold with supply treated as low
    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
            st.s1.mr_n <= 1'b1;
            st.s2.mr_n <= 1'b1;
            st.supply_low <= 1'b1;
            st.phase <= SSW_HOLD;
            st.out.reset_n <= RST_ASSERTED_N;
            st.out.reset_hi <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rst_out = st.out;

    // ==========================================================
    // assertions
    supply_low_rst_a: assert property (@(posedge mclk) disable iff (rst)
        st.supply_low |=> !rst_out.reset_n)
        else $error("reset released while supply low");

    hold_delay_rst_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(rst_out.reset_n) |-> st.hold_cnt == CNT_W'(HOLD_CYC - 1))
        else $error("reset released before hold delay");

    hold_count_a: assert property (@(posedge mclk) disable iff (rst)
        (st.phase == SSW_HOLD && !any_cause && st.hold_cnt < CNT_W'(HOLD_CYC - 1))
        |=> st.hold_cnt == $past(st.hold_cnt) + CNT_W'(1))
        else $error("hold counter did not advance");

    manual_force_a: assert property (@(posedge mclk) disable iff (rst)
        !st.s2.mr_n |=> !rst_out.reset_n ##1 !rst_out.reset_n)
        else $error("manual reset did not force reset");

    mr_release_a: assert property (@(posedge mclk) disable iff (rst)
        (mr_active && !st.supply_low) |=> st.hold_cnt == '0)
        else $error("manual release did not restart hold");

    wdog_expiry_a: assert property (@(posedge mclk) disable iff (rst)
        st.wdog_fire |=> !rst_out.reset_n)
        else $error("watchdog expiry did not reset");

    wdog_clear_a: assert property (@(posedge mclk) disable iff (rst)
        (kick_edge || st.phase == SSW_HOLD) |=> st.wdog_cnt == '0)
        else $error("watchdog not cleared");

    polarity_pair_a: assert property (@(posedge mclk) disable iff (rst)
        rst_out.reset_hi == !rst_out.reset_n)
        else $error("reset outputs disagree");

    hyst_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (st.supply_low && !st.s2.above) |=> st.supply_low)
        else $error("supply low left without upper trip");

    wdog_supply_a: assert property (@(posedge mclk) disable iff (rst)
        st.supply_low |=> !st.wdog_fire)
        else $error("watchdog fired with supply low");

    // ==========================================================
    // hold phase and output pairing
    hi_follows_phase_a: assert property (@(posedge mclk) disable iff (rst)
        rst_out.reset_hi == (st.phase != SSW_RUN))
        else $error("high reset out of step with phase");

    lo_follows_phase_a: assert property (@(posedge mclk) disable iff (rst)
        rst_out.reset_n == (st.phase == SSW_RUN))
        else $error("low reset out of step with phase");

    run_cause_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (st.phase == SSW_RUN && any_cause) |=> st.phase == SSW_HOLD)
        else $error("cause did not enter hold");

    hold_stays_a: assert property (@(posedge mclk) disable iff (rst)
        (st.phase == SSW_HOLD && any_cause) |=> st.phase == SSW_HOLD)
        else $error("hold left while a cause was active");

    cause_clears_cnt_a: assert property (@(posedge mclk) disable iff (rst)
        (st.phase == SSW_HOLD && any_cause) |=> st.hold_cnt == '0)
        else $error("hold counter not restarted by cause");

    hold_full_a: assert property (@(posedge mclk) disable iff (rst)
        (st.phase == SSW_HOLD && st.hold_cnt < CNT_W'(HOLD_CYC - 1))
        |=> st.phase == SSW_HOLD)
        else $error("hold left before count complete");

    hold_bound_a: assert property (@(posedge mclk) disable iff (rst)
        st.hold_cnt <= CNT_W'(HOLD_CYC - 1))
        else $error("hold counter ran past its end");

    run_cnt_full_a: assert property (@(posedge mclk) disable iff (rst)
        st.phase == SSW_RUN |-> st.hold_cnt == CNT_W'(HOLD_CYC - 1))
        else $error("running without a full hold");

    hold_exit_a: assert property (@(posedge mclk) disable iff (rst)
        (st.phase == SSW_HOLD && !any_cause && st.hold_cnt == CNT_W'(HOLD_CYC - 1))
        |=> rst_out.reset_n)
        else $error("reset not released after full hold");

    release_clean_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(rst_out.reset_n) |-> !$past(st.supply_low) && $past(st.s2.mr_n))
        else $error("reset released with a cause present");

    // ==========================================================
    // input synchronisers and hysteresis
    sync_stage_a: assert property (@(posedge mclk) disable iff (rst)
        st.s2 == $past(st.s1))
        else $error("second sync stage out of step");

    kick_delay_a: assert property (@(posedge mclk) disable iff (rst)
        st.kick_d == $past(st.s2.kick))
        else $error("kick edge flop out of step");

    hyst_enter_a: assert property (@(posedge mclk) disable iff (rst)
        st.s2.below |=> st.supply_low)
        else $error("supply low not entered");

    hyst_leave_a: assert property (@(posedge mclk) disable iff (rst)
        (!st.s2.below && st.s2.above) |=> !st.supply_low)
        else $error("supply low not left above upper trip");

    mr_absent_a: assert property (@(posedge mclk) disable iff (rst)
        !HAS_MR |-> st.s2.mr_n)
        else $error("manual reset seen in variant without it");

    // ==========================================================
    // watchdog counter
    wdog_bound_a: assert property (@(posedge mclk) disable iff (rst)
        st.wdog_cnt <= CNT_W'(WDOG_CYCLES - 1))
        else $error("watchdog counter ran past timeout");

    wdog_count_a: assert property (@(posedge mclk) disable iff (rst)
        (HAS_WDOG && !kick_edge && st.phase == SSW_RUN && !any_cause
        && st.wdog_cnt < CNT_W'(WDOG_CYCLES - 1))
        |=> st.wdog_cnt == $past(st.wdog_cnt) + CNT_W'(1))
        else $error("watchdog counter did not advance");

    wdog_off_a: assert property (@(posedge mclk) disable iff (rst)
        !HAS_WDOG |-> !st.wdog_fire)
        else $error("disabled watchdog fired");

    fire_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        st.wdog_fire |=> !st.wdog_fire)
        else $error("watchdog fire longer than one cycle");

    hold_no_fire_a: assert property (@(posedge mclk) disable iff (rst)
        st.phase == SSW_HOLD |=> !st.wdog_fire)
        else $error("watchdog fired during hold");

    low_clears_wdog_a: assert property (@(posedge mclk) disable iff (rst)
        st.supply_low |=> st.wdog_cnt == '0)
        else $error("watchdog counted with supply low");

    mr_clears_wdog_a: assert property (@(posedge mclk) disable iff (rst)
        mr_active |=> st.wdog_cnt == '0)
        else $error("watchdog counted during manual reset");

    fire_needs_run_a: assert property (@(posedge mclk) disable iff (rst)
        st.wdog_fire |-> $past(st.phase) == SSW_RUN)
        else $error("watchdog fired outside run");

    fire_needs_good_a: assert property (@(posedge mclk) disable iff (rst)
        st.wdog_fire |-> !$past(st.supply_low))
        else $error("watchdog fired after supply low");

endmodule : ssw_supervisor

// *** verif/ssw_proc_model.sv ***
// processor stand-in for the reset generator: toggles the watchdog kick
// assumes the generator's active-low reset and a bench enable that models a hang
`timescale 1ns/1ps
module ssw_proc_model #(
    parameter int unsigned PERIOD = 10
) (
    input wire logic mclk,
    input wire logic sys_reset_n,
    input wire logic kick_en,
    output logic kick
);
    int unsigned cnt = 0;
    initial kick = 1'b0;
    // ========
    // kick generator
    // a hung program just stops toggling; a held processor never kicks
    always @(posedge mclk) begin
        if (sys_reset_n && kick_en) begin
            cnt <= (cnt + 1) % PERIOD;
            if (cnt == PERIOD - 1) kick <= ~kick;
        end else begin
            cnt <= 0;
        end
    end
endmodule : ssw_proc_model

// *** verif/supply_supervisor_watchdog_reset_tb.sv ***
// self-checking bench for the supply supervisor reset generator
// assumes shortened hold and watchdog counts so the run stays short
`timescale 1ns/1ps
module supply_supervisor_watchdog_reset_tb;
    import ssw_pkg::*;
    localparam int HOLD = 20;
    localparam int WDOG = 50;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic below = 1'b1;
    logic above = 1'b0;
    logic mr_n = 1'b1;
    logic kick_en = 1'b1;
    logic kick;
    ssw_rst_out_t rst_out;
    ssw_rst_out_t rst_out_nomr;
    int err_count = 0;
    int checked = 0;
    // ========
    // clock, design and processor model
    initial begin
        forever #50 mclk = ~mclk;
    end
    ssw_supervisor #(.WDOG_CYCLES(WDOG), .HOLD_CYC(HOLD)) dut (.mclk(mclk), .rst(rst),
        .below_lower_trip(below), .above_upper_trip(above), .manual_reset_n(mr_n),
        .watchdog_kick_input(kick), .rst_out(rst_out));
    // variant without manual reset and without watchdog, on the same supply
    ssw_supervisor #(.WDOG_CYCLES(WDOG), .HOLD_CYC(HOLD), .HAS_MR(1'b0), .HAS_WDOG(1'b0))
        dut_nomr (.mclk(mclk), .rst(rst), .below_lower_trip(below),
        .above_upper_trip(above), .manual_reset_n(mr_n),
        .watchdog_kick_input(1'b0), .rst_out(rst_out_nomr));
    ssw_proc_model #(.PERIOD(10)) proc (.mclk(mclk), .sys_reset_n(rst_out.reset_n),
        .kick_en(kick_en), .kick(kick));
    // ========
    // shared helpers
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    // bounded wait for the active-low reset to reach a level
    task automatic wait_lvl(input logic v, input int lim, output int n);
        n = 0;
        while (rst_out.reset_n !== v && n < lim) begin
            @(negedge mclk);
            n++;
        end
    endtask : wait_lvl
    // hold must be full, yet not much longer than the sync latency adds
    task automatic hold_time(input int slack);
        int n;
        wait_lvl(1'b1, 200, n);
        chk("hold min", 32'(n >= HOLD - slack), 1);
        chk("hold max", 32'(n <= HOLD + 6), 1);
        chk("high out", rst_out.reset_hi, 0);
    endtask : hold_time
    // ========
    // scenarios
    task automatic t_supply();
        repeat (5) @(negedge mclk);
        chk("low out", rst_out.reset_n, 0);
        chk("high out", rst_out.reset_hi, 1);
        chk("nomr low", rst_out_nomr.reset_n, 0);
        @(posedge mclk) below <= 1'b0;
        repeat (HOLD + 10) @(negedge mclk);
        chk("hyst", rst_out.reset_n, 0);
        @(posedge mclk) above <= 1'b1;
        hold_time(0);
        $display("test supply done");
    endtask : t_supply
    task automatic t_manual();
        @(posedge mclk) mr_n <= 1'b0;
        repeat (5) @(negedge mclk);
        chk("mr low", rst_out.reset_n, 0);
        chk("nomr kept", rst_out_nomr.reset_n, 1);
        @(posedge mclk) mr_n <= 1'b1;
        repeat (10) @(negedge mclk);
        @(posedge mclk) mr_n <= 1'b0;
        repeat (3) @(posedge mclk);
        mr_n <= 1'b1;
        hold_time(0);
        $display("test manual done");
    endtask : t_manual
    task automatic t_wdog();
        int n;
        int lows;
        lows = 0;
        repeat (3 * WDOG) begin
            @(negedge mclk);
            if (rst_out.reset_n !== 1'b1) lows++;
        end
        chk("kicked", lows, 0);
        @(posedge mclk) kick_en <= 1'b0;
        repeat (WDOG - 12) @(negedge mclk);
        chk("wd early", rst_out.reset_n, 1);
        wait_lvl(1'b0, 25, n);
        chk("wd fire", rst_out.reset_n, 0);
        chk("nowd kept", rst_out_nomr.reset_n, 1);
        @(posedge mclk) kick_en <= 1'b1;
        hold_time(2);
        $display("test watchdog done");
    endtask : t_wdog
    // ========
    // run control
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_supply();
        t_manual();
        t_wdog();
        final_report();
    end
    // the tests need well under a thousand cycles
    initial begin
        #(5000 * 100);
        err_count++;
        final_report();
    end
endmodule : supply_supervisor_watchdog_reset_tb
